/* File: verilog/embs_consts.vh */
// Constants for the external memory bus strobe generator
// Functional notes
// - Latch strobe at osc/6, osc/3 double
// - Latch strobe marks low address capture
// - Skip one latch pulse per data access
// - Aux bit 0 silences latch internally
// - Program read strobe twice per cycle
// - Data access drops two program reads
// - No program read on internal fetch
// - Access pin low forces external fetch
// - Pin high: external above internal top
// - Security level 1 latches pin at reset
// - Speed bit selects 12 or 6 clocks
// - Reset gives standard speed mode
// - Double speed halves peripheral reference
`ifndef EMBS_CONSTS_VH
`define EMBS_CONSTS_VH
`define EMBS_PHASE_W 4
`define EMBS_NORM_LAST 4'h000b
`define EMBS_FAST_LAST 4'h0005
`define EMBS_NORM_HALF 4'h0006
`define EMBS_FAST_HALF 4'h0003
`define EMBS_NORM_ALE_END 4'h0002
`define EMBS_FAST_ALE_END 4'h0001
`define EMBS_NORM_RD_BEG 4'h0003
`define EMBS_NORM_RD_END 4'h0005
`define EMBS_FAST_RD_BEG 4'h0001
`define EMBS_FAST_RD_END 4'h0002
`define EMBS_AUX_ALE_OFF 0
`define EMBS_CK_FAST 0
`define EMBS_TOP_16K 16'h3fff
`define EMBS_TOP_32K 16'h7fff
`define EMBS_PER_W 4
`define EMBS_PER_NORM_LAST 4'h000b
`define EMBS_PER_FAST_LAST 4'h0005
`endif

/* File: verilog/embs_phase.v */
// Machine-cycle phase sequencer
`timescale 1ns/1ps
`default_nettype none
`include "embs_consts.vh"
module embs_phase (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Mode
  input wire double_speed,
  // Phase state
  output reg [`EMBS_PHASE_W-1:0] phase,
  output reg cycle_end
);
  wire [`EMBS_PHASE_W-1:0] last;
  // Length follows the selected mode; a change takes effect at the cycle boundary
  assign last = double_speed ? `EMBS_FAST_LAST : `EMBS_NORM_LAST;
  always @(posedge clk) begin
    if (!reset_n) begin
      phase <= {`EMBS_PHASE_W{1'b0}};
      cycle_end <= 1'b0;
    end else begin
      if (phase >= last) begin
        phase <= {`EMBS_PHASE_W{1'b0}};
      end else begin
        phase <= phase + 1'b1;
      end
      cycle_end <= (phase == last - 1'b1);
    end
  end
endmodule // embs_phase
`default_nettype wire

/* File: verilog/embs_strobes.v */
// External memory bus strobe generator top
`timescale 1ns/1ps
`default_nettype none
`include "embs_consts.vh"
module embs_strobes (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Control register bits
  input wire [7:0] aux_control_reg,
  input wire [7:0] clock_control_reg,
  input wire security_level1,
  input wire variant_32k,
  // Core status
  input wire [15:0] program_counter,
  input wire data_access_req,
  // Pins
  input wire external_access_select,
  // Bus strobes
  output reg address_latch_strobe,
  output reg program_read_strobe_n,
  // Status
  output reg fetch_external,
  output reg double_speed,
  output reg machine_cycle_pulse,
  output reg periph_tick
);
  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  // Two stages without reset, so the pin has settled before reset lifts
  reg pin_meta;
  reg pin_sync;
  always @(posedge clk) begin
    pin_meta <= external_access_select;
    pin_sync <= pin_meta;
  end

  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  // Taken once from the synchronised pin at the first edge after release;
  // the pin must be steady for two clocks before that edge
  localparam STRAP_WAIT = 1'b0;
  localparam STRAP_HELD = 1'b1;
  reg strap_state;
  reg next_strap_state;
  reg pin_strap;
  reg next_pin_strap;
  always @* begin
    next_strap_state = strap_state;
    next_pin_strap = pin_strap;
    case (strap_state)
      STRAP_WAIT: begin
        next_strap_state = STRAP_HELD;
        next_pin_strap = pin_sync;
      end
      STRAP_HELD: begin
        next_pin_strap = pin_strap;
      end
      default: begin
        next_strap_state = STRAP_WAIT;
      end
    endcase
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      strap_state <= STRAP_WAIT;
      pin_strap <= 1'b0;
    end else begin
      strap_state <= next_strap_state;
      pin_strap <= next_pin_strap;
    end
  end
  wire pin_level;
  // Live pin costs two cycles of latency; the strap copy is frozen
  assign pin_level = security_level1 ? pin_strap : pin_sync;

  // ------------------------------------------------------------
  // Speed mode
  // ------------------------------------------------------------
  wire [`EMBS_PHASE_W-1:0] phase;
  wire cycle_end;
  // A new speed is taken only at a machine-cycle boundary, so no cycle
  // mixes both lengths and both strobes move over together
  localparam MODE_NORM = 1'b0;
  localparam MODE_FAST = 1'b1;
  reg mode;
  reg next_mode;
  wire speed_req;
  assign speed_req = clock_control_reg[`EMBS_CK_FAST];
  always @* begin
    next_mode = mode;
    case (mode)
      MODE_NORM: begin
        if (speed_req && cycle_end) begin
          next_mode = MODE_FAST;
        end
      end
      MODE_FAST: begin
        if (!speed_req && cycle_end) begin
          next_mode = MODE_NORM;
        end
      end
      default: begin
        next_mode = MODE_NORM;
      end
    endcase
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      mode <= MODE_NORM;
    end else begin
      mode <= next_mode;
    end
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      double_speed <= 1'b0;
    end else begin
      double_speed <= (next_mode == MODE_FAST);
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  embs_phase u_phase (
    .clk(clk),
    .reset_n(reset_n),
    .double_speed(double_speed),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // ------------------------------------------------------------
  // Fetch source
  // ------------------------------------------------------------
  // True when the fetch address lies past the on-chip code space
  function beyond_top;
    input [15:0] pc;
    input big;
    begin
      if (big) begin
        beyond_top = (pc > `EMBS_TOP_32K);
      end else begin
        beyond_top = (pc > `EMBS_TOP_16K);
      end
    end
  endfunction

  reg next_fetch_external;
  always @* begin
    next_fetch_external = 1'b1;
    case (pin_level)
      1'b0: begin
        next_fetch_external = 1'b1;
      end
      1'b1: begin
        next_fetch_external = beyond_top(program_counter, variant_32k);
      end
      default: begin
        next_fetch_external = 1'b1;
      end
    endcase
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      fetch_external <= 1'b0;
    end else begin
      fetch_external <= next_fetch_external;
    end
  end

  // ------------------------------------------------------------
  // Data access skip
  // ------------------------------------------------------------
  // A request seen during a cycle makes the next machine cycle a data cycle,
  // which drops the first of its two latch pulses and both read pulses
  reg data_pending;
  reg data_cycle;
  reg next_data_pending;
  reg next_data_cycle;
  always @* begin
    next_data_pending = data_pending;
    next_data_cycle = data_cycle;
    if (cycle_end) begin
      next_data_cycle = data_pending || data_access_req;
      next_data_pending = 1'b0;
    end else if (data_access_req) begin
      next_data_pending = 1'b1;
    end
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      data_pending <= 1'b0;
      data_cycle <= 1'b0;
    end else begin
      data_pending <= next_data_pending;
      data_cycle <= next_data_cycle;
    end
  end

  // ------------------------------------------------------------
  // Strobe decode
  // ------------------------------------------------------------
  function in_range;
    input [`EMBS_PHASE_W-1:0] p;
    input [`EMBS_PHASE_W-1:0] lo;
    input [`EMBS_PHASE_W-1:0] hi;
    begin
      in_range = (p >= lo) && (p < hi);
    end
  endfunction

  // Picks the constant of the active speed mode
  function [`EMBS_PHASE_W-1:0] pick;
    input fast;
    input [`EMBS_PHASE_W-1:0] norm_val;
    input [`EMBS_PHASE_W-1:0] fast_val;
    begin
      pick = fast ? fast_val : norm_val;
    end
  endfunction

  wire [`EMBS_PHASE_W-1:0] half;
  wire [`EMBS_PHASE_W-1:0] half_phase;
  wire [`EMBS_PHASE_W-1:0] ale_end;
  wire [`EMBS_PHASE_W-1:0] rd_beg;
  wire [`EMBS_PHASE_W-1:0] rd_end;
  assign half = pick(double_speed, `EMBS_NORM_HALF, `EMBS_FAST_HALF);
  assign half_phase = (phase >= half) ? (phase - half) : phase;
  assign ale_end = pick(double_speed, `EMBS_NORM_ALE_END, `EMBS_FAST_ALE_END);
  assign rd_beg = pick(double_speed, `EMBS_NORM_RD_BEG, `EMBS_FAST_RD_BEG);
  assign rd_end = pick(double_speed, `EMBS_NORM_RD_END, `EMBS_FAST_RD_END);

  wire ale_slot;
  wire rd_slot;
  wire ale_skip;
  wire ale_off;
  // Two latch slots per cycle give osc/6 standard, osc/3 double
  assign ale_slot = in_range(half_phase, {`EMBS_PHASE_W{1'b0}}, ale_end);
  assign rd_slot = in_range(half_phase, rd_beg, rd_end);
  // Only the first latch pulse of a data cycle is dropped
  assign ale_skip = data_cycle && (phase < half);
  assign ale_off = aux_control_reg[`EMBS_AUX_ALE_OFF] && !fetch_external;

  reg next_address_latch_strobe;
  reg next_program_read_strobe_n;
  always @* begin
    next_address_latch_strobe = 1'b0;
    next_program_read_strobe_n = 1'b1;
    if (ale_slot && !ale_skip && !ale_off) begin
      next_address_latch_strobe = 1'b1;
    end
    if (rd_slot && fetch_external && !data_cycle) begin
      next_program_read_strobe_n = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      address_latch_strobe <= 1'b0;
      program_read_strobe_n <= 1'b1;
    end else begin
      address_latch_strobe <= next_address_latch_strobe;
      program_read_strobe_n <= next_program_read_strobe_n;
    end
  end
  // Cycle marker comes one clock before the first latch slot of each cycle
  always @(posedge clk) begin
    if (!reset_n) begin
      machine_cycle_pulse <= 1'b0;
    end else begin
      machine_cycle_pulse <= cycle_end;
    end
  end

  // ------------------------------------------------------------
  // Peripheral time reference
  // ------------------------------------------------------------
  reg [`EMBS_PER_W-1:0] per_count;
  reg [`EMBS_PER_W-1:0] next_per_count;
  reg next_periph_tick;
  wire [`EMBS_PER_W-1:0] per_last;
  // Free running from the same reset and limits as the phase counter, so it stays in step with the bus strobes
  assign per_last = pick(double_speed, `EMBS_PER_NORM_LAST, `EMBS_PER_FAST_LAST);
  always @* begin
    next_per_count = per_count + 1'b1;
    next_periph_tick = 1'b0;
    if (per_count >= per_last) begin
      next_per_count = {`EMBS_PER_W{1'b0}};
      next_periph_tick = 1'b1;
    end
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      per_count <= {`EMBS_PER_W{1'b0}};
      periph_tick <= 1'b0;
    end else begin
      per_count <= next_per_count;
      periph_tick <= next_periph_tick;
    end
  end
endmodule // embs_strobes
`default_nettype wire

/* File: test/embs_ext_mem.sv */
// External memory model that counts the bus strobes it sees
`timescale 1ns/1ps
`default_nettype none
module embs_ext_mem (
  // Clock and window control
  input wire logic clk,
  input wire logic clear,
  // Bus strobes
  input wire logic ale,
  input wire logic rd_n,
  // Strobe counts
  output var logic [7:0] latch_cnt,
  output var logic [7:0] read_cnt
);
  logic ale_q;
  logic rd_q;
  // Each rising latch edge and each falling read edge adds one to its count
  always @(posedge clk) begin
    ale_q <= ale;
    rd_q <= rd_n;
    latch_cnt <= clear ? 8'h00 : latch_cnt + {7'h00, ale & ~ale_q};
    read_cnt <= clear ? 8'h00 : read_cnt + {7'h00, rd_q & ~rd_n};
  end
endmodule // embs_ext_mem
`default_nettype wire

/* File: test/embs_strobes_checker.sv */
// Port assertions for the bus strobe generator
`timescale 1ns/1ps
`default_nettype none
module embs_strobes_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Inputs
  input wire logic [7:0] aux_control_reg,
  input wire logic [7:0] clock_control_reg,
  input wire logic security_level1,
  input wire logic variant_32k,
  input wire logic [15:0] program_counter,
  input wire logic data_access_req,
  input wire logic external_access_select,
  // Outputs
  input wire logic address_latch_strobe,
  input wire logic program_read_strobe_n,
  input wire logic fetch_external,
  input wire logic double_speed,
  input wire logic machine_cycle_pulse,
  input wire logic periph_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_latch_std: assert property (!double_speed && $rose(address_latch_strobe) |=>
    address_latch_strobe ##1 !address_latch_strobe) else $error("latch width");
  a_read_std: assert property (!double_speed && $fell(program_read_strobe_n) |=>
    !program_read_strobe_n ##1 program_read_strobe_n) else $error("read width");
  a_read_internal: assert property (!fetch_external [*3] |-> program_read_strobe_n)
    else $error("read on internal fetch");
  a_latch_off: assert property ((aux_control_reg[0] && !fetch_external) [*3]
    |-> !address_latch_strobe) else $error("latch not silenced");
  a_cycle_std: assert property (!double_speed && machine_cycle_pulse
    |=> !machine_cycle_pulse [*8]) else $error("machine cycle short");
  a_pin_low: assert property ((!security_level1 && !external_access_select) [*8]
    |-> fetch_external) else $error("pin low not external");
  a_above_top: assert property ((!security_level1 && external_access_select
    && program_counter > 16'h7fff) [*8] |-> fetch_external) else $error("top fetch");
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=>
    !address_latch_strobe && program_read_strobe_n && !double_speed) else $error("reset");
endmodule // embs_strobes_checker
`default_nettype wire

/* File: test/embs_strobes_bench.sv */
// Self-checking bench for the bus strobe generator
`timescale 1ns/1ps
`default_nettype none
module embs_strobes_bench;
  logic clk, reset_n, security_level1, variant_32k, data_access_req, clear;
  logic external_access_select, address_latch_strobe, program_read_strobe_n;
  logic fetch_external, double_speed, machine_cycle_pulse, periph_tick;
  logic [7:0] aux_control_reg, clock_control_reg, lc, rc, tk;
  logic [15:0] program_counter;
  int miscompares, tests_run, cyc;
  embs_strobes u_embs_strobes (.*);
  embs_ext_mem u_embs_ext_mem (.clk(clk), .clear(clear), .ale(address_latch_strobe),
    .rd_n(program_read_strobe_n), .latch_cnt(lc), .read_cnt(rc));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tk <= clear ? 8'h00 : tk + {7'h00, periph_tick};
    if (cyc == 4000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // Windows span whole machine cycles, so edge counts do not depend on phase
  task automatic meas(input logic dq, input logic [7:0] el, input logic [7:0] er,
    input logic [7:0] et);
    repeat (24) @(negedge clk);
    clear = 1'b1;
    @(negedge clk);
    {clear, data_access_req} = {1'b0, dq};
    @(negedge clk);
    data_access_req = 1'b0;
    repeat (119) @(negedge clk);
    chk("latch", el, lc);
    chk("read", er, rc);
    chk("tick", et, tk);
  endtask
  task automatic rst();
    reset_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
  endtask
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {reset_n, security_level1, variant_32k, data_access_req, clear} = 5'h00;
    {aux_control_reg, clock_control_reg, program_counter} = 32'h0000_0000;
    tk = 8'h00;
    external_access_select = 1'b0;
    @(negedge clk);
    rst();
    meas(1'b0, 8'h14, 8'h14, 8'h0a);
    clock_control_reg = 8'h01;
    meas(1'b0, 8'h28, 8'h28, 8'h14);
    clock_control_reg = 8'h00;
    meas(1'b1, 8'h13, 8'h12, 8'h0a);
    external_access_select = 1'b1;
    meas(1'b0, 8'h14, 8'h00, 8'h0a);
    aux_control_reg = 8'h01;
    meas(1'b0, 8'h00, 8'h00, 8'h0a);
    {aux_control_reg, program_counter} = 24'h00_4000;
    meas(1'b0, 8'h14, 8'h14, 8'h0a);
    variant_32k = 1'b1;
    meas(1'b0, 8'h14, 8'h00, 8'h0a);
    program_counter = 16'h8000;
    meas(1'b0, 8'h14, 8'h14, 8'h0a);
    {security_level1, external_access_select, program_counter} = 18'h2_0000;
    rst();
    // The pin is sampled once after release; move it only afterwards
    repeat (2) @(negedge clk);
    external_access_select = 1'b1;
    meas(1'b0, 8'h14, 8'h14, 8'h0a);
    conclude();
  end
endmodule // embs_strobes_bench
bind embs_strobes embs_strobes_checker u_embs_strobes_checker (.*);
`default_nettype wire
